// [pkg/pattern_detect_pkg.sv]
// shared constants and types for the masked pattern detector
package pattern_detect_pkg;

  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int unsigned RES_W = 48;

  // ---------------------------------------------------------------
  // register offsets (register port, 4-bit word address)
  // ---------------------------------------------------------------
  localparam logic [3:0] OFS_CTRL    = 4'h0;
  localparam logic [3:0] OFS_PAT_LO  = 4'h1;
  localparam logic [3:0] OFS_PAT_HI  = 4'h2;
  localparam logic [3:0] OFS_MASK_LO = 4'h3;
  localparam logic [3:0] OFS_MASK_HI = 4'h4;
  localparam logic [3:0] OFS_STATUS  = 4'h5;

  // ---------------------------------------------------------------
  // control field positions
  // ---------------------------------------------------------------
  localparam int unsigned CTRL_SEL_PAT_BIT  = 0;
  localparam int unsigned CTRL_SEL_MASK_BIT = 1;
  localparam int unsigned CTRL_ROUND_LSB    = 2;
  localparam int unsigned CTRL_USED_BIT     = 4;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [47:0] PATTERN_RST = 48'h000000000000;
  localparam logic [47:0] MASK_RST    = 48'h3FFFFFFFFFFF;
  localparam logic [31:0] CTRL_RST    = 32'h00000010;

  // rounding mask choices
  typedef enum logic [1:0] {
    ROUND_NORMAL            = 2'b00,
    symmetric_round_choice  = 2'b01,
    convergent_round_choice = 2'b10
  } round_sel_e;

  // detector configuration bundle
  typedef struct packed {
    logic        sel_pat_dyn;
    logic        sel_mask_dyn;
    round_sel_e  round_sel;
    logic        detector_used;
    logic [47:0] pattern;
    logic [47:0] mask;
  } det_cfg_s;

  // flag bundle
  typedef struct packed {
    logic match;
    logic match_inv;
    logic ovf;
    logic unf;
  } det_flags_s;

endpackage : pattern_detect_pkg

// [verilog/match_core.sv]
// combinational masked match of a result against a pattern
`timescale 1ns/1ps
module match_core #(
  parameter int unsigned W = 48
) (
  // operands
  input  wire logic [W-1:0] i_res,
  input  wire logic [W-1:0] i_pat,
  input  wire logic [W-1:0] i_mask,
  // flags
  output logic              o_eq,
  output logic              o_eq_inv
);
  // ones in the mask drop that bit from both compares
  assign o_eq     = &((~(i_res ^ i_pat)) | i_mask);
  assign o_eq_inv = &(( (i_res ^ i_pat)) | i_mask);
endmodule : match_core

// [verilog/masked_pattern_detector.sv]
// masked pattern detector on a 48-bit slice result
//
// Overview of operation
// - flag when the result equals the pattern, and separately when it equals its complement.
// - masked bit positions never affect either flag.
// - pattern and mask are 48 bits wide.
// - the static pattern defaults to all zeros.
// - the static mask defaults to 3FFFFFFFFFFF and sets the overflow threshold.
// - pattern source is static pattern or dynamic third operand, static by default.
// - mask source is static mask or dynamic third operand, static by default.
// - rounding mask choice is normal, symmetric or convergent, and overrides mask source.
// - flags appear in the same cycle as the result they belong to.
// - with the logic unit a logic function of two operands is compared to the pattern.
// - the detector-used setting never changes function.
// - zero pattern and zero mask flag all-zeros and all-ones results.
// - with defaults, overflow and underflow report crossing result bit 46.
// - overflow and underflow flags are high for one cycle only; outside logic holds them.
//
// The implementer's own choices: the register addresses and strobed register access.
`timescale 1ns/1ps
module masked_pattern_detector
  import pattern_detect_pkg::*;
#(
  parameter int unsigned W = 48
) (
  // clock and reset
  input  wire logic                         i_clk,
  input  wire logic                         i_rst,
  // register port
  input  wire logic [3:0]                   i_addr,
  input  wire logic [31:0]                  i_wdata,
  input  wire logic                         i_wr,
  input  wire logic                         i_rd,
  output logic      [31:0]                  o_rdata,
  // datapath operands
  input  wire logic [W-1:0]                 i_x,
  input  wire logic [W-1:0]                 i_z,
  input  wire logic [W-1:0]                 i_c,
  input  wire logic [3:0]                   i_alu_op,
  // result and flags
  output logic      [W-1:0]                 o_result,
  output logic                              o_match_flag_out,
  output logic                              o_match_inv,
  output logic                              o_overflow,
  output logic                              o_underflow
);
  import pattern_detect_pkg::*;

  // ---------------------------------------------------------------
  // logic unit / adder ops
  // ---------------------------------------------------------------
  localparam logic [3:0] OP_ADD  = 4'h0;
  localparam logic [3:0] OP_SUB  = 4'h3;
  localparam logic [3:0] OP_XNOR = 4'h5;
  localparam logic [3:0] OP_AND  = 4'hC;
  localparam logic [3:0] OP_OR   = 4'hE;
  localparam logic [3:0] OP_NAND = 4'hD;
  localparam logic [3:0] OP_XOR  = 4'h4;

  // arithmetic and logic stage; picks a function of the two operands
  function automatic logic [W-1:0] alu_fn(input logic [3:0] op,
                                          input logic [W-1:0] a,
                                          input logic [W-1:0] b);
    logic [W-1:0] r;
    r = a + b;
    if (op == OP_SUB) begin
      r = a - b;
    end else if (op == OP_XNOR) begin
      r = ~(a ^ b);
    end else if (op == OP_XOR) begin
      r = a ^ b;
    end else if (op == OP_AND) begin
      r = a & b;
    end else if (op == OP_NAND) begin
      r = ~(a & b);
    end else if (op == OP_OR) begin
      r = a | b;
    end
    return r;
  endfunction : alu_fn

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  logic [31:0]  ctrl_ff;
  logic [W-1:0] pat_ff;
  logic [W-1:0] mask_ff;
  logic [31:0]  rdata_ff;
  logic [31:0]  nxt_rdata;
  det_cfg_s     cfg;

  wire wr_ctrl    = i_wr && (i_addr == OFS_CTRL);
  wire wr_pat_lo  = i_wr && (i_addr == OFS_PAT_LO);
  wire wr_pat_hi  = i_wr && (i_addr == OFS_PAT_HI);
  wire wr_mask_lo = i_wr && (i_addr == OFS_MASK_LO);
  wire wr_mask_hi = i_wr && (i_addr == OFS_MASK_HI);

  // static pattern and mask keep their defaults until software writes
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ctrl_ff <= CTRL_RST;
      pat_ff  <= PATTERN_RST[W-1:0];
      mask_ff <= MASK_RST[W-1:0];
    end else begin
      if (wr_ctrl)    ctrl_ff        <= i_wdata;
      if (wr_pat_lo)  pat_ff[31:0]   <= i_wdata;
      if (wr_pat_hi)  pat_ff[W-1:32] <= i_wdata[W-33:0];
      if (wr_mask_lo) mask_ff[31:0]  <= i_wdata;
      if (wr_mask_hi) mask_ff[W-1:32] <= i_wdata[W-33:0];
    end
  end

  assign cfg.sel_pat_dyn   = ctrl_ff[CTRL_SEL_PAT_BIT];
  assign cfg.sel_mask_dyn  = ctrl_ff[CTRL_SEL_MASK_BIT];
  assign cfg.round_sel     = round_sel_e'(ctrl_ff[CTRL_ROUND_LSB +: 2]);
  // only reported back; no datapath signal reads it
  assign cfg.detector_used = ctrl_ff[CTRL_USED_BIT];
  assign cfg.pattern       = pat_ff;
  assign cfg.mask          = mask_ff;

  // ---------------------------------------------------------------
  // pattern and mask selection
  // ---------------------------------------------------------------
  wire [W-1:0] sel_pat  = cfg.sel_pat_dyn ? i_c : cfg.pattern;
  wire [W-1:0] base_msk = cfg.sel_mask_dyn ? i_c : cfg.mask;
  // rounding masks derive from the third operand: symmetric ignores the
  // bits where it is zero, convergent shifts that mask up one bit and also ignores bit 0
  wire [W-1:0] sym_msk  = ~i_c;
  wire [W-1:0] conv_msk = {~i_c[W-2:0], 1'b1};
  wire [W-1:0] sel_msk  = (cfg.round_sel == symmetric_round_choice)  ? sym_msk :
                          (cfg.round_sel == convergent_round_choice) ? conv_msk :
                          base_msk;

  // ---------------------------------------------------------------
  // datapath result and same-cycle compare
  // ---------------------------------------------------------------
  // the compare looks at the next result so the flag registers with it
  wire [W-1:0] nxt_result = alu_fn(i_alu_op, i_z, i_x);
  logic        eq_now;
  logic        eq_inv_now;

  match_core #(.W(W)) u_match (
    .i_res    (nxt_result),
    .i_pat    (sel_pat),
    .i_mask   (sel_msk),
    .o_eq     (eq_now),
    .o_eq_inv (eq_inv_now)
  );

  logic [W-1:0] result_ff;
  logic         match_ff;
  logic         match_inv_ff;
  logic         match_prev_ff;
  logic         match_inv_prev_ff;
  logic         ovf_ff;
  logic         unf_ff;

  // previous-cycle match says the accumulator was in range; losing it
  // means the result left the window set by the mask
  wire nxt_ovf = match_ff && !eq_now && !eq_inv_now && !nxt_result[W-1];
  wire nxt_unf = match_inv_ff && !eq_now && !eq_inv_now && nxt_result[W-1];

  // result and flags load together, so they always describe the same word
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      result_ff    <= '0;
      match_ff     <= 1'b0;
      match_inv_ff <= 1'b0;
      ovf_ff       <= 1'b0;
      unf_ff       <= 1'b0;
    end else begin
      result_ff    <= nxt_result;
      match_ff     <= eq_now;
      match_inv_ff <= eq_inv_now;
      ovf_ff       <= nxt_ovf;
      unf_ff       <= nxt_unf;
    end
  end

  // previous flag copies only feed assertions
  always_ff @(posedge i_clk) begin
    match_prev_ff     <= match_ff;
    match_inv_prev_ff <= match_inv_ff;
  end

  // ---------------------------------------------------------------
  // register read port
  // ---------------------------------------------------------------
  wire [31:0] status_w = {28'h0000000, unf_ff, ovf_ff, match_inv_ff, match_ff};

  always_comb begin
    nxt_rdata = 32'h00000000;
    if (i_rd) begin
      if (i_addr == OFS_CTRL) begin
        nxt_rdata = ctrl_ff;
      end else if (i_addr == OFS_PAT_LO) begin
        nxt_rdata = pat_ff[31:0];
      end else if (i_addr == OFS_PAT_HI) begin
        nxt_rdata = {16'h0000, pat_ff[W-1:32]};
      end else if (i_addr == OFS_MASK_LO) begin
        nxt_rdata = mask_ff[31:0];
      end else if (i_addr == OFS_MASK_HI) begin
        nxt_rdata = {16'h0000, mask_ff[W-1:32]};
      end else if (i_addr == OFS_STATUS) begin
        nxt_rdata = status_w;
      end
    end
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge i_clk) begin
    if (i_rst) rdata_ff <= 32'h00000000;
    else       rdata_ff <= nxt_rdata;
  end

  assign o_rdata          = rdata_ff;
  assign o_result         = result_ff;
  assign o_match_flag_out = match_ff;
  assign o_match_inv      = match_inv_ff;
  assign o_overflow       = ovf_ff;
  assign o_underflow      = unf_ff;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  // compare inputs one edge back, lined up with the registered flags
  logic [W-1:0] cmp_mask_ff;
  logic [W-1:0] cmp_pat_ff;

  always_ff @(posedge i_clk) begin
    cmp_mask_ff <= sel_msk;
    cmp_pat_ff  <= sel_pat;
  end

  // overflow takes two steps: in range one cycle, out of range the next
  sequence seq_leave_high;
    match_ff ##1 (!match_ff && !match_inv_ff && !result_ff[W-1]);
  endsequence

  sequence seq_leave_low;
    match_inv_ff ##1 (!match_ff && !match_inv_ff && result_ff[W-1]);
  endsequence

  AST_OVF_SEQ: assert property (@(posedge i_clk) disable iff (i_rst)
    seq_leave_high |-> o_overflow)
    else $error("leaving the range upward gave no overflow");

  AST_UNF_SEQ: assert property (@(posedge i_clk) disable iff (i_rst)
    seq_leave_low |-> o_underflow)
    else $error("leaving the range downward gave no underflow");

  AST_MATCH_EXACT: assert property (@(posedge i_clk) disable iff (i_rst)
    !$past(i_rst) |-> (match_ff == (((result_ff ^ cmp_pat_ff) & ~cmp_mask_ff) == '0)))
    else $error("match flag disagrees with masked compare");

  AST_MATCH_INV: assert property (@(posedge i_clk) disable iff (i_rst)
    !$past(i_rst) |-> (match_inv_ff == (((~result_ff ^ cmp_pat_ff) & ~cmp_mask_ff) == '0)))
    else $error("complement flag disagrees with masked compare");

  AST_ALL_MASKED: assert property (@(posedge i_clk) disable iff (i_rst)
    ($past(sel_msk) == '1 && !$past(i_rst)) |-> (match_ff && match_inv_ff))
    else $error("fully masked compare did not match");

  AST_ZERO_CASE: assert property (@(posedge i_clk) disable iff (i_rst)
    ($past(sel_msk) == '0 && $past(sel_pat) == '0 && !$past(i_rst))
      |-> (match_ff == (result_ff == '0)) && (match_inv_ff == (result_ff == '1)))
    else $error("zero pattern zero mask flags wrong");

  AST_DYN_PATTERN: assert property (@(posedge i_clk) disable iff (i_rst)
    cfg.sel_pat_dyn |=>
      (match_ff == (((result_ff ^ $past(i_c)) & ~cmp_mask_ff) == '0)))
    else $error("dynamic pattern not taken from third operand");

  AST_DYN_MASK: assert property (@(posedge i_clk) disable iff (i_rst)
    (cfg.sel_mask_dyn && cfg.round_sel == ROUND_NORMAL) |=>
      (match_ff == (((result_ff ^ cmp_pat_ff) & ~$past(i_c)) == '0)))
    else $error("dynamic mask not taken from third operand");

  AST_ROUND_OVERRIDE: assert property (@(posedge i_clk) disable iff (i_rst)
    (cfg.round_sel == symmetric_round_choice) |=>
      (match_ff == (((result_ff ^ cmp_pat_ff) & $past(i_c)) == '0)))
    else $error("rounding mask did not override mask source");

  AST_ROUND_CONV: assert property (@(posedge i_clk) disable iff (i_rst)
    (cfg.round_sel == convergent_round_choice) |=>
      (match_ff == (((result_ff ^ cmp_pat_ff) & {$past(i_c[W-2:0]), 1'b0}) == '0)))
    else $error("convergent mask did not override mask source");

  AST_SAME_CYCLE: assert property (@(posedge i_clk) disable iff (i_rst)
    (result_ff == cmp_pat_ff && cmp_mask_ff == '0 && !$past(i_rst)) |-> match_ff)
    else $error("flag not aligned with its result");

  AST_OVF_PULSE: assert property (@(posedge i_clk) disable iff (i_rst)
    o_overflow |=> !o_overflow)
    else $error("overflow flag held longer than one cycle");

  AST_UNF_PULSE: assert property (@(posedge i_clk) disable iff (i_rst)
    o_underflow |=> !o_underflow)
    else $error("underflow flag held longer than one cycle");

  AST_OVF_CAUSE: assert property (@(posedge i_clk) disable iff (i_rst)
    o_overflow |-> (match_prev_ff && !match_ff && !match_inv_ff && !result_ff[W-1]))
    else $error("overflow without leaving the range");

  AST_UNF_CAUSE: assert property (@(posedge i_clk) disable iff (i_rst)
    o_underflow |-> (match_inv_prev_ff && !match_ff && !match_inv_ff && result_ff[W-1]))
    else $error("underflow without leaving the range");

  AST_NO_STICKY: assert property (@(posedge i_clk) disable iff (i_rst)
    ($past(sel_msk) == '0 && $past(sel_pat) == '0 && result_ff != '0 && !$past(i_rst))
      |-> !match_ff)
    else $error("match flag held without a match");

endmodule : masked_pattern_detector

// [tb/fabric_sat.sv]
// fabric-side saturation register fed by the detector's one-cycle flags
`timescale 1ns/1ps
module fabric_sat (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst,
  // detector flags
  input  wire logic i_ovf,
  input  wire logic i_unf,
  // held saturation selects
  output logic      o_pos_ff,
  output logic      o_neg_ff
);
  // flags last one cycle only, so the fabric keeps them until the opposite event
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_pos_ff <= 1'b0;
      o_neg_ff <= 1'b0;
    end else if (i_ovf | i_unf) begin
      o_pos_ff <= i_ovf;
      o_neg_ff <= i_unf;
    end
  end
endmodule : fabric_sat

// [tb/test_masked_pattern_detector.sv]
// self-checking bench for the masked pattern detector
`timescale 1ns/1ps
module test_masked_pattern_detector;
  import pattern_detect_pkg::*;
  logic        clk, rst, wr, rd, mf, mi, ovf, unf, pos, neg;
  logic [3:0]  adr, op;
  logic [31:0] wd, rdat;
  logic [47:0] x, z, c, res;
  int          errors, num_checks;

  masked_pattern_detector dut (
    .i_clk(clk), .i_rst(rst), .i_addr(adr), .i_wdata(wd), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdat), .i_x(x), .i_z(z), .i_c(c), .i_alu_op(op), .o_result(res),
    .o_match_flag_out(mf), .o_match_inv(mi), .o_overflow(ovf), .o_underflow(unf)
  );
  fabric_sat partner (
    .i_clk(clk), .i_rst(rst), .i_ovf(ovf), .i_unf(unf), .o_pos_ff(pos), .o_neg_ff(neg)
  );

  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic cmp_val(input logic [47:0] got, exp, input string m);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : cmp_val

  task automatic cmp_bit(input logic got, exp, input string m);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t %s got %b exp %b", $time, m, got, exp);
    end
  endtask : cmp_bit

  // expected arithmetic, worked out independently of the design
  function automatic logic [47:0] alu(input logic [3:0] o, input logic [47:0] a, b);
    case (o)
      4'h3: return a - b;
      4'h4: return a ^ b;
      4'h5: return ~(a ^ b);
      4'hC: return a & b;
      4'hD: return ~(a & b);
      4'hE: return a | b;
      default: return a + b;
    endcase
  endfunction : alu

  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    adr <= a;
    wd  <= d;
    wr  <= 1'b1;
    @(posedge clk);
    wr  <= 1'b0;
  endtask : wr_reg

  // read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk);
    adr <= a;
    rd  <= 1'b1;
    @(posedge clk);
    rd  <= 1'b0;
    #1;
    cmp_val({16'h0000, rdat}, {16'h0000, e}, "read");
  endtask : rd_chk

  task automatic wr48(input logic [3:0] a, input logic [47:0] v);
    wr_reg(a, v[31:0]);
    wr_reg(a + 4'h1, {16'h0000, v[47:32]});
  endtask : wr48

  // one operand set in, result and both flags out one edge later
  task automatic step(input logic [3:0] o, input logic [47:0] zz, xx, cc,
                      input logic em, ei);
    @(posedge clk);
    op <= o;
    z  <= zz;
    x  <= xx;
    c  <= cc;
    @(posedge clk);
    #1;
    cmp_val(res, alu(o, zz, xx), "result");
    cmp_bit(mf, em, "match");
    cmp_bit(mi, ei, "match_inv");
  endtask : step

  task automatic t_regs;
    rd_chk(OFS_CTRL, 32'h00000010);
    rd_chk(OFS_PAT_LO, 32'h00000000);
    rd_chk(OFS_PAT_HI, 32'h00000000);
    rd_chk(OFS_MASK_LO, 32'hFFFFFFFF);
    rd_chk(OFS_MASK_HI, 32'h00003FFF);
    rd_chk(4'hF, 32'h00000000);
  endtask : t_regs

  // default mask: crossing bit 46 either way gives a single-cycle pulse
  task automatic t_overflow;
    step(4'h0, 48'h3FFFFFFFFFFF, 48'h0, 48'h0, 1'b1, 1'b0);
    step(4'h0, 48'h3FFFFFFFFFFF, 48'h1, 48'h0, 1'b0, 1'b0);
    cmp_bit(ovf, 1'b1, "ovf");
    cmp_bit(unf, 1'b0, "unf");
    @(posedge clk);
    #1;
    cmp_bit(ovf, 1'b0, "ovf width");
    cmp_bit(pos, 1'b1, "sat pos");
    step(4'h0, 48'hC00000000000, 48'h0, 48'h0, 1'b0, 1'b1);
    step(4'h3, 48'hC00000000000, 48'h1, 48'h0, 1'b0, 1'b0);
    cmp_bit(unf, 1'b1, "unf");
    @(posedge clk);
    #1;
    cmp_bit(unf, 1'b0, "unf width");
    cmp_bit(neg, 1'b1, "sat neg");
  endtask : t_overflow

  // zero pattern and mask: logic functions tested for all zeros / all ones
  task automatic t_logic;
    logic [47:0] k;
    k = 48'h5A5A1234C3C3;
    wr48(OFS_MASK_LO, 48'h0);
    step(4'h4, k, k, 48'h0, 1'b1, 1'b0);
    step(4'h5, k, k, 48'h0, 1'b0, 1'b1);
    step(4'hC, k, ~k, 48'h0, 1'b1, 1'b0);
    step(4'hD, k, ~k, 48'h0, 1'b0, 1'b1);
    step(4'hE, k, ~k, 48'h0, 1'b0, 1'b1);
    step(4'h3, k, k, 48'h0, 1'b1, 1'b0);
    step(4'h0, k, ~k, 48'h0, 1'b0, 1'b1);
    rd_chk(OFS_STATUS, 32'h00000002);
  endtask : t_logic

  // dynamic mask and pattern from the third operand; detector marked unused
  task automatic t_dyn;
    wr48(OFS_PAT_LO, 48'h923456789ABC);
    wr_reg(OFS_CTRL, 32'h00000002);
    step(4'h0, 48'h923456789AB3, 48'h0, 48'hF, 1'b1, 1'b0);
    step(4'h0, 48'h923456789BBC, 48'h0, 48'hF, 1'b0, 1'b0);
    step(4'h0, 48'h123456789ABC, 48'h0, 48'hF, 1'b0, 1'b0);
    step(4'h0, 48'h0123456789AB, 48'h0, 48'hFFFFFFFFFFFF, 1'b1, 1'b1);
    wr_reg(OFS_CTRL, 32'h00000001);
    step(4'h0, 48'hFEDCBA987654, 48'h0, 48'hFEDCBA987654, 1'b1, 1'b0);
    step(4'h0, 48'h0123456789AB, 48'h0, 48'hFEDCBA987654, 1'b0, 1'b1);
  endtask : t_dyn

  // special rounding masks override the mask source
  task automatic t_round;
    wr_reg(OFS_CTRL, 32'h00000004);
    step(4'h0, 48'h0000000000BC, 48'h0, 48'hFF, 1'b1, 1'b0);
    wr_reg(OFS_CTRL, 32'h00000016);
    step(4'h0, 48'h923456789A00, 48'h0, 48'hFF, 1'b0, 1'b0);
    wr_reg(OFS_CTRL, 32'h00000008);
    step(4'h0, 48'h0000000000BD, 48'h0, 48'hFF, 1'b1, 1'b0);
    step(4'h0, 48'h0000000000BE, 48'h0, 48'hFE, 1'b1, 1'b0);
    step(4'h0, 48'h0000000001BC, 48'h0, 48'hFE, 1'b0, 1'b0);
  endtask : t_round

  task automatic report_and_stop;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : report_and_stop

  // watchdog: the sequence needs under a hundred cycles
  initial begin
    repeat (3000) @(posedge clk);
    errors++;
    report_and_stop();
  end

  initial begin
    rst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    adr = 4'h0;
    wd = 32'h0;
    op = 4'h0;
    x = 48'h0;
    z = 48'h0;
    c = 48'h0;
    errors = 0;
    num_checks = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_overflow();
    t_logic();
    t_dyn();
    t_round();
    report_and_stop();
  end
endmodule : test_masked_pattern_detector
